// ---- include/tms_consts.svh ----
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH

// Register byte offsets
`define TMS_OFS_CTRL     12'h000
`define TMS_OFS_COUNT    12'h004
`define TMS_OFS_CMPA     12'h008
`define TMS_OFS_CMPB     12'h00C
`define TMS_OFS_CAPT     12'h010
`define TMS_OFS_FLAGS    12'h014
`define TMS_OFS_STATUS   12'h018

// Control field positions
`define TMS_CTRL_MODE_LSB 0
`define TMS_CTRL_MODE_MSB 3
`define TMS_CTRL_ACTA_LSB 4
`define TMS_CTRL_ACTA_MSB 5
`define TMS_CTRL_ACTB_LSB 6
`define TMS_CTRL_ACTB_MSB 7
`define TMS_CTRL_DIRA     8
`define TMS_CTRL_DIRB     9
`define TMS_CTRL_CSEL_LSB 10
`define TMS_CTRL_CSEL_MSB 12

// Flag bit positions
`define TMS_FLG_OVF  0
`define TMS_FLG_CMPA 1
`define TMS_FLG_CMPB 2
`define TMS_FLG_CAPT 3

// Counter values
`define TMS_BOTTOM 16'h0000
`define TMS_MAX    16'hFFFF
`define TMS_TOP8   16'h00FF
`define TMS_TOP9   16'h01FF
`define TMS_TOP10  16'h03FF

// Reset values
`define TMS_WORD_RST 16'h0000
`define TMS_DATA_RST 32'h0000_0000

// Prescaler terminal counts for N = 1, 8, 64, 256, 1024
`define TMS_PSC_TC1    10'h000
`define TMS_PSC_TC8    10'h007
`define TMS_PSC_TC64   10'h03F
`define TMS_PSC_TC256  10'h0FF
`define TMS_PSC_TC1024 10'h3FF

`endif

// ---- include/tms_pkg.sv ----
`include "tms_consts.svh"

package tms_pkg;
    typedef logic [15:0] tms_word_t;
    typedef logic [11:0] tms_addr_t;
    typedef logic [31:0] tms_data_t;

    typedef enum logic [1:0] {
        TMS_ACT_NONE   = 2'h0,
        TMS_ACT_TOGGLE = 2'h1,
        TMS_ACT_CLEAR  = 2'h2,
        TMS_ACT_SET    = 2'h3
    } tms_act_e;

    typedef enum logic [3:0] {
        TMS_MODE_NORMAL    = 4'h0,
        TMS_MODE_CLEAR_A   = 4'h4,
        TMS_MODE_FPWM8     = 4'h5,
        TMS_MODE_FPWM9     = 4'h6,
        TMS_MODE_FPWM10    = 4'h7,
        TMS_MODE_CLEAR_CAP = 4'hC,
        TMS_MODE_FPWM_CAP  = 4'hE,
        TMS_MODE_FPWM_A    = 4'hF
    } tms_mode_e;
endpackage : tms_pkg

// ---- logic/tms_prescaler.sv ----
`timescale 1ns/1ps
`include "tms_consts.svh"

module tms_prescaler (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    // Division select
    input  wire logic [2:0] sel,
    // Timer clock tick
    output logic            tick
);
    import tms_pkg::*;

    logic [9:0] cnt;
    logic [9:0] next_cnt;
    logic [9:0] tc;
    logic       run;

    // Select 0 stops the timer, 6 and 7 too
    always_comb begin
        run = 1'h1;
        unique case (sel)
            3'h1: tc = `TMS_PSC_TC1;
            3'h2: tc = `TMS_PSC_TC8;
            3'h3: tc = `TMS_PSC_TC64;
            3'h4: tc = `TMS_PSC_TC256;
            3'h5: tc = `TMS_PSC_TC1024;
            default: begin
                tc  = 10'h000;
                run = 1'h0;
            end
        endcase
    end

    assign tick = run & (cnt == tc); // [RQ20] [RQ23]

    always_comb begin
        next_cnt = (!run || tick) ? 10'h000 : cnt + 10'h001;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt <= 10'h000;
        end else if (ce) begin
            cnt <= next_cnt;
        end
    end

    a_stopped_no_tick: assert property (@(posedge clk) disable iff (!reset_n) // [RQ23]
        (sel == 3'h0) |-> !tick)
        else $error("tick while prescaler stopped");
endmodule : tms_prescaler

// ---- logic/tms_channel.sv ----
`timescale 1ns/1ps
`include "tms_consts.svh"

module tms_channel (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    // Timer events match and bottom, already gated by the tick, then PWM mode qualifiers
    input  wire logic              match,
    input  wire logic              bottom,
    input  wire logic              pwm,
    input  wire logic              toggle_ok,
    // Configuration
    input  wire tms_pkg::tms_act_e action,
    input  wire logic              dir,
    // Pin
    output logic                   oc,
    output logic                   oe
);
    import tms_pkg::*;

    logic next_oc;

    always_comb begin
        next_oc = oc;
        if (pwm) begin
            unique case (action)
                TMS_ACT_NONE: next_oc = oc;
                TMS_ACT_TOGGLE: begin
                    if (match && toggle_ok) next_oc = ~oc;
                end
                // Bottom applied last so compare equal to top gives a constant level
                TMS_ACT_CLEAR: begin
                    if (match) next_oc = 1'h0; // [RQ11]
                    if (bottom) next_oc = 1'h1; // [RQ11]
                end
                TMS_ACT_SET: begin
                    if (match) next_oc = 1'h1; // [RQ11]
                    if (bottom) next_oc = 1'h0; // [RQ11]
                end
            endcase
        end else if (match) begin
            unique case (action)
                TMS_ACT_NONE:   next_oc = oc;
                TMS_ACT_TOGGLE: next_oc = ~oc; // [RQ8]
                TMS_ACT_CLEAR:  next_oc = 1'h0;
                TMS_ACT_SET:    next_oc = 1'h1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oc <= 1'h0;
        end else if (ce) begin
            oc <= next_oc;
        end
    end

    assign oe = dir & (action != TMS_ACT_NONE); // [RQ1] [RQ8]

    a_match_toggle: assert property (@(posedge clk) disable iff (!reset_n) // [RQ8]
        ce && match && !pwm && action == TMS_ACT_TOGGLE |=> oc != $past(oc))
        else $error("output did not toggle on match");

    a_bottom_level: assert property (@(posedge clk) disable iff (!reset_n) // [RQ11]
        ce && bottom && pwm && action inside {TMS_ACT_CLEAR, TMS_ACT_SET}
        |=> oc == ($past(action) == TMS_ACT_CLEAR))
        else $error("wrong output level at bottom");
endmodule : tms_channel

// ---- logic/tms_timer16.sv ----
`timescale 1ns/1ps
`include "tms_consts.svh"
// Overview of operation
// [RQ1] Mode field alone sets counting; action field only shapes the output pins.
// [RQ2] Normal mode always increments, never cleared by match, wraps FFFF to 0000.
// [RQ3] Normal mode sets overflow flag when count becomes zero; counting never clears it.
// [RQ4] Normal mode accepts a software count write at any time.
// [RQ5] Clear modes zero the counter on top match; mode 4 uses A, 12 capture.
// [RQ6] Clear modes set compare A or capture flag, whichever defines top, at top.
// [RQ7] Clear-mode top writes act at once; top below count runs through FFFF.
// [RQ8] Clear mode with action A toggle flips output A each match; pin needs direction.
// [RQ9] Clear modes set overflow flag when counter rolls from FFFF to 0000.
// [RQ10] Modes 5, 6, 7, 14, 15 count bottom to top then restart.
// [RQ11] Fast PWM non-inverting clears on match, sets at bottom; inverting opposite.
// [RQ12] Fast PWM top is 00FF, 01FF, 03FF, capture or A; clear after top.
// [RQ13] Software keeps register-defined PWM top at 0003 or more.
// [RQ14] Fast PWM sets overflow at top plus compare A or capture flag.
// [RQ15] Fast PWM sets each channel's flag whenever count equals its compare value.
// [RQ16] Fixed top masks compare writes to the fixed resolution.
// [RQ17] Software keeps top at or above compares; compare above top never matches.
// [RQ18] Fast PWM capture top is unbuffered; low top runs counter through FFFF.
// [RQ19] Fast PWM compare A writes go to a buffer, loaded at top.
// [RQ20] Toggle frequency is clock over 2*N*(1+A), N from 1, 8, 64, 256, 1024.
// [RQ21] Compare flags clear on service acknowledge or on writing one.
// [RQ22] A count write suppresses compare matches at the next timer tick.
// [RQ23] Counter and flags advance only on prescaler ticks.

module tms_timer16 (
    // Clock, reset, enable
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               ce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire tms_pkg::tms_addr_t paddr,
    input  wire tms_pkg::tms_data_t pwdata,
    output tms_pkg::tms_data_t      prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Flag service acknowledge
    input  wire logic [3:0]         flag_ack,
    // Compare output pins
    output logic                    compare_a_output,
    output logic                    compare_a_oe,
    output logic                    channel_compare_output_b,
    output logic                    channel_compare_oe_b
);
    import tms_pkg::*;

    // Control state
    logic [3:0] waveform_mode_select;
    logic [3:0] next_waveform_mode_select;
    tms_act_e   output_action_select_a;
    tms_act_e   next_output_action_select_a;
    tms_act_e   output_action_select_b;
    tms_act_e   next_output_action_select_b;
    logic       output_pin_direction_bit_a;
    logic       next_output_pin_direction_bit_a;
    logic       output_pin_direction_bit_b;
    logic       next_output_pin_direction_bit_b;
    logic [2:0] clock_select;
    logic [2:0] next_clock_select;

    // Timer state
    tms_word_t  count_value;
    tms_word_t  next_count_value;
    tms_word_t  compare_a_value;
    tms_word_t  next_compare_a_value;
    tms_word_t  compare_a_active;
    tms_word_t  next_compare_a_active;
    tms_word_t  channel_compare_value_b;
    tms_word_t  next_channel_compare_value_b;
    tms_word_t  capture_top_value;
    tms_word_t  next_capture_top_value;
    logic       match_block;
    logic       next_match_block;
    logic [3:0] flags;
    logic [3:0] next_flags;
    tms_data_t  next_prdata;

    // Decode
    logic       acc;
    logic       wr_en;
    logic       mapped;
    logic       ctrl_wr;
    logic       count_wr;
    logic       cmpa_wr;
    logic       cmpb_wr;
    logic       capt_wr;
    logic       flags_wr;

    // Sequencer
    logic       tick;
    logic       tick_en;
    tms_word_t  top;
    tms_word_t  cmp_mask;
    tms_word_t  wmask;
    logic       is_pwm;
    logic       is_clear_mode;
    logic       fixed_top;
    logic       cap_top;
    logic       at_top;
    logic       match_a;
    logic       match_b;
    logic       top_wrap;
    logic       ovf_set;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;

    assign acc      = psel & penable & ce;
    assign wr_en    = acc & pwrite;
    assign ctrl_wr  = wr_en & (paddr == `TMS_OFS_CTRL);
    assign count_wr = wr_en & (paddr == `TMS_OFS_COUNT);
    assign cmpa_wr  = wr_en & (paddr == `TMS_OFS_CMPA);
    assign cmpb_wr  = wr_en & (paddr == `TMS_OFS_CMPB);
    assign capt_wr  = wr_en & (paddr == `TMS_OFS_CAPT);
    assign flags_wr = wr_en & (paddr == `TMS_OFS_FLAGS);
    assign mapped   = (paddr == `TMS_OFS_CTRL) | (paddr == `TMS_OFS_COUNT)
                    | (paddr == `TMS_OFS_CMPA) | (paddr == `TMS_OFS_CMPB)
                    | (paddr == `TMS_OFS_CAPT) | (paddr == `TMS_OFS_FLAGS)
                    | (paddr == `TMS_OFS_STATUS);
    // Status register is read-only
    assign pready   = ce;
    assign pslverr  = psel & penable & (~mapped | (pwrite & (paddr == `TMS_OFS_STATUS)));

    tms_prescaler u_prescaler (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .sel     (clock_select),
        .tick    (tick)
    );

    assign tick_en = ce & tick; // [RQ23]

    // Top selection depends on the mode field only
    always_comb begin
        unique case (waveform_mode_select)
            TMS_MODE_FPWM8:     top = `TMS_TOP8; // [RQ12]
            TMS_MODE_FPWM9:     top = `TMS_TOP9; // [RQ12]
            TMS_MODE_FPWM10:    top = `TMS_TOP10; // [RQ12]
            TMS_MODE_CLEAR_CAP,
            TMS_MODE_FPWM_CAP:  top = capture_top_value; // [RQ5] [RQ12]
            TMS_MODE_CLEAR_A,
            TMS_MODE_FPWM_A:    top = compare_a_active; // [RQ5] [RQ12]
            default:            top = `TMS_MAX; // [RQ1] [RQ2]
        endcase
    end

    assign is_pwm        = waveform_mode_select inside {TMS_MODE_FPWM8, TMS_MODE_FPWM9,
                           TMS_MODE_FPWM10, TMS_MODE_FPWM_CAP, TMS_MODE_FPWM_A}; // [RQ10]
    assign is_clear_mode = waveform_mode_select inside {TMS_MODE_CLEAR_A, TMS_MODE_CLEAR_CAP};
    assign fixed_top     = waveform_mode_select inside {TMS_MODE_FPWM8, TMS_MODE_FPWM9,
                           TMS_MODE_FPWM10};
    assign cap_top       = waveform_mode_select inside {TMS_MODE_CLEAR_CAP, TMS_MODE_FPWM_CAP};

    // Equality only, so a compare above top never matches
    assign at_top   = (count_value == top) & ~match_block; // [RQ17] [RQ22]
    assign match_a  = (count_value == compare_a_active) & ~match_block; // [RQ15] [RQ22]
    assign match_b  = (count_value == channel_compare_value_b) & ~match_block; // [RQ15] [RQ22]
    assign top_wrap = tick_en & at_top & (is_clear_mode | is_pwm); // [RQ5] [RQ12]
    assign ovf_set  = tick_en & (is_pwm ? at_top : (count_value == `TMS_MAX)); // [RQ3] [RQ9] [RQ14]

    assign cmp_mask = fixed_top ? top : `TMS_MAX;
    assign wmask    = pwdata[15:0] & cmp_mask; // [RQ16]

    always_comb begin
        next_count_value             = count_value;
        next_compare_a_value         = compare_a_value;
        next_compare_a_active        = compare_a_active;
        next_channel_compare_value_b = channel_compare_value_b;
        next_capture_top_value       = capture_top_value;
        next_match_block             = match_block;
        if (tick_en) begin
            next_match_block = 1'h0;
            // A missed top lets the counter run on through MAX and wrap
            if (top_wrap) begin
                next_count_value = `TMS_BOTTOM; // [RQ5] [RQ10] [RQ12]
            end else begin
                next_count_value = count_value + 16'h0001; // [RQ2] [RQ7] [RQ18]
            end
            if (is_pwm && at_top) begin
                next_compare_a_active = compare_a_value; // [RQ19]
            end
        end
        if (count_wr) begin
            next_count_value = pwdata[15:0]; // [RQ4]
            next_match_block = 1'h1; // [RQ22]
        end
        if (cmpa_wr) begin
            next_compare_a_value = wmask; // [RQ19]
            if (!is_pwm) begin
                next_compare_a_active = wmask; // [RQ7]
            end
        end
        if (cmpb_wr) begin
            next_channel_compare_value_b = wmask; // [RQ16]
        end
        if (capt_wr) begin
            next_capture_top_value = pwdata[15:0]; // [RQ7] [RQ18]
        end
    end

    // Flags: set wins over any clear in the same cycle
    assign flag_set[`TMS_FLG_OVF]  = ovf_set; // [RQ3] [RQ9] [RQ14]
    assign flag_set[`TMS_FLG_CMPA] = tick_en & match_a; // [RQ6] [RQ14] [RQ15]
    assign flag_set[`TMS_FLG_CMPB] = tick_en & match_b; // [RQ15]
    assign flag_set[`TMS_FLG_CAPT] = tick_en & at_top & cap_top; // [RQ6] [RQ14]
    assign flag_clr = (flags_wr ? pwdata[3:0] : 4'h0) | flag_ack; // [RQ21]

    always_comb begin
        next_flags = (flags & ~flag_clr) | flag_set; // [RQ3] [RQ21]
    end

    always_comb begin
        next_waveform_mode_select       = waveform_mode_select;
        next_output_action_select_a     = output_action_select_a;
        next_output_action_select_b     = output_action_select_b;
        next_output_pin_direction_bit_a = output_pin_direction_bit_a;
        next_output_pin_direction_bit_b = output_pin_direction_bit_b;
        next_clock_select               = clock_select;
        if (ctrl_wr) begin
            next_waveform_mode_select =
                pwdata[`TMS_CTRL_MODE_MSB:`TMS_CTRL_MODE_LSB];
            next_output_action_select_a =
                tms_act_e'(pwdata[`TMS_CTRL_ACTA_MSB:`TMS_CTRL_ACTA_LSB]);
            next_output_action_select_b =
                tms_act_e'(pwdata[`TMS_CTRL_ACTB_MSB:`TMS_CTRL_ACTB_LSB]);
            next_output_pin_direction_bit_a = pwdata[`TMS_CTRL_DIRA];
            next_output_pin_direction_bit_b = pwdata[`TMS_CTRL_DIRB];
            next_clock_select = pwdata[`TMS_CTRL_CSEL_MSB:`TMS_CTRL_CSEL_LSB];
        end
    end

    // Read data captured in the setup cycle
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `TMS_OFS_CTRL: begin
                    next_prdata = {19'h0, clock_select, output_pin_direction_bit_b,
                                   output_pin_direction_bit_a, output_action_select_b,
                                   output_action_select_a, waveform_mode_select};
                end
                `TMS_OFS_COUNT:  next_prdata = {16'h0000, count_value};
                `TMS_OFS_CMPA:   next_prdata = {16'h0000, compare_a_value};
                `TMS_OFS_CMPB:   next_prdata = {16'h0000, channel_compare_value_b};
                `TMS_OFS_CAPT:   next_prdata = {16'h0000, capture_top_value};
                `TMS_OFS_FLAGS:  next_prdata = {28'h0, flags};
                `TMS_OFS_STATUS: begin
                    next_prdata = {14'h0, channel_compare_output_b, compare_a_output,
                                   compare_a_active};
                end
                default:         next_prdata = `TMS_DATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= `TMS_DATA_RST;
        end else begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            waveform_mode_select       <= 4'h0;
            output_action_select_a     <= TMS_ACT_NONE;
            output_action_select_b     <= TMS_ACT_NONE;
            output_pin_direction_bit_a <= 1'h0;
            output_pin_direction_bit_b <= 1'h0;
            clock_select               <= 3'h0;
            count_value                <= `TMS_WORD_RST;
            compare_a_value            <= `TMS_WORD_RST;
            compare_a_active           <= `TMS_WORD_RST;
            channel_compare_value_b    <= `TMS_WORD_RST;
            capture_top_value          <= `TMS_WORD_RST;
            match_block                <= 1'h0;
            flags                      <= 4'h0;
        end else if (ce) begin
            waveform_mode_select       <= next_waveform_mode_select;
            output_action_select_a     <= next_output_action_select_a;
            output_action_select_b     <= next_output_action_select_b;
            output_pin_direction_bit_a <= next_output_pin_direction_bit_a;
            output_pin_direction_bit_b <= next_output_pin_direction_bit_b;
            clock_select               <= next_clock_select;
            count_value                <= next_count_value;
            compare_a_value            <= next_compare_a_value;
            compare_a_active           <= next_compare_a_active;
            channel_compare_value_b    <= next_channel_compare_value_b;
            capture_top_value          <= next_capture_top_value;
            match_block                <= next_match_block;
            flags                      <= next_flags;
        end
    end

    // Toggle on A allowed in every non-PWM mode and in PWM only with A as top
    tms_channel u_chan_a (
        .clk       (clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .match     (tick_en & match_a),
        .bottom    (top_wrap & is_pwm),
        .pwm       (is_pwm),
        .toggle_ok (waveform_mode_select == TMS_MODE_FPWM_A),
        .action    (output_action_select_a),
        .dir       (output_pin_direction_bit_a),
        .oc        (compare_a_output),
        .oe        (compare_a_oe)
    );

    tms_channel u_chan_b (
        .clk       (clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .match     (tick_en & match_b),
        .bottom    (top_wrap & is_pwm),
        .pwm       (is_pwm),
        .toggle_ok (1'h0),
        .action    (output_action_select_b),
        .dir       (output_pin_direction_bit_b),
        .oc        (channel_compare_output_b),
        .oe        (channel_compare_oe_b)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_plain_tick;
        tick_en && !count_wr;
    endsequence

    sequence s_pwm_top;
        s_plain_tick ##0 (is_pwm && at_top && !cmpa_wr);
    endsequence

    a_normal_wrap: assert property ( // [RQ2]
        s_plain_tick ##0 (waveform_mode_select == TMS_MODE_NORMAL && count_value == `TMS_MAX)
        |=> count_value == `TMS_BOTTOM && flags[`TMS_FLG_OVF])
        else $error("normal mode did not wrap with overflow");

    a_ovf_sticky: assert property ( // [RQ3]
        flags[`TMS_FLG_OVF] && ce && !flag_clr[`TMS_FLG_OVF] |=> flags[`TMS_FLG_OVF])
        else $error("overflow flag cleared without request");

    a_count_write: assert property ( // [RQ4]
        count_wr |=> count_value == $past(pwdata[15:0]) && match_block)
        else $error("count write not taken");

    a_clear_top: assert property ( // [RQ5]
        s_plain_tick ##0 (is_clear_mode && at_top) |=> count_value == `TMS_BOTTOM)
        else $error("clear mode did not clear at top");

    a_capt_flag: assert property ( // [RQ6]
        tick_en && at_top && cap_top |=> flags[`TMS_FLG_CAPT])
        else $error("capture flag not set at top");

    a_pwm_top_load: assert property ( // [RQ19]
        s_pwm_top |=> compare_a_active == $past(compare_a_value)
        && count_value == `TMS_BOTTOM && flags[`TMS_FLG_OVF])
        else $error("top update incomplete");

    a_match_block: assert property ( // [RQ22]
        match_block && tick_en && !flags[`TMS_FLG_CMPB] |=> !flags[`TMS_FLG_CMPB])
        else $error("blocked match set compare flag");

    a_fixed_mask: assert property ( // [RQ16]
        cmpb_wr && fixed_top |=> (channel_compare_value_b & ~$past(top)) == `TMS_BOTTOM)
        else $error("compare write not masked");

    a_cmpb_flag: assert property ( // [RQ15]
        tick_en && match_b |=> flags[`TMS_FLG_CMPB])
        else $error("compare flag missed a match");

    a_no_tick_hold: assert property ( // [RQ23]
        !tick_en && !count_wr && !flag_clr[`TMS_FLG_OVF]
        |=> $stable(count_value) && $stable(flags[`TMS_FLG_OVF]))
        else $error("counter moved without tick");
endmodule : tms_timer16

// ---- verification/tms_timer16_tb_top.sv ----
`timescale 1ns/1ps
`include "tms_consts.svh"
module tms_timer16_tb_top;
    import tms_pkg::*;
    typedef struct {
        logic [9:0] ctrl;
        tms_word_t  cmpa, capt, cnt;
        int         cyc;
        logic [3:0] flg;
        tms_word_t  bnd;
        bit         above;
    } tms_row_s;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       psel = 1'b0;
    logic       penable = 1'b0;
    logic       pwrite = 1'b0;
    tms_addr_t  paddr = '0;
    tms_data_t  pwdata = '0;
    logic [3:0] flag_ack = 4'h0;
    tms_data_t  prdata, q, c;
    logic       pready, pslverr, err, oa, oea, ob, oeb, oa0;
    int         fails = 0;
    int         samples_checked = 0;
    // Mode, compare A, top, start count, cycles, flags, count bound, above bound
    tms_row_s   rows[12] = '{
        '{10'h0, 16'h0, 16'h0, 16'hFFF0, 40, 4'h3, 16'h30, 0},
        '{10'h4, 16'h5, 16'h0, 16'h0, 30, 4'h2, 16'h5, 0},
        '{10'hC, 16'h100, 16'h7, 16'h0, 30, 4'h8, 16'h7, 0},
        '{10'h4, 16'h3, 16'h0, 16'h10, 30, 4'h0, 16'h3, 1},
        '{10'h4, 16'h5, 16'h0, 16'h5, 30, 4'h0, 16'h5, 1},
        '{10'h4, 16'h1000, 16'h0, 16'hFFF0, 40, 4'h1, 16'h30, 0},
        '{10'h5, 16'h80, 16'h0, 16'hF0, 60, 4'h1, 16'h40, 0},
        '{10'hE, 16'h100, 16'h9, 16'h0, 40, 4'h9, 16'h9, 0},
        '{10'hF, 16'h9, 16'h0, 16'h0, 300, 4'h3, 16'h9, 0},
        '{10'hE, 16'h9, 16'h10, 16'h20, 30, 4'h0, 16'h10, 1},
        '{10'h7, 16'h100, 16'h0, 16'h3F0, 40, 4'h1, 16'h40, 0},
        '{10'h6, 16'h100, 16'h0, 16'h1F0, 40, 4'h1, 16'h40, 0}};
    tms_timer16 tms_timer16_i (.clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag_ack(flag_ack),
        .compare_a_output(oa), .compare_a_oe(oea), .channel_compare_output_b(ob),
        .channel_compare_oe_b(oeb));
    always #25 clk = ~clk;
    task automatic chk(input string n, input tms_data_t e, input tms_data_t g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input tms_addr_t a, input tms_data_t d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk_reset;
        for (int a = 0; a < 7; a++) begin
            apb(0, tms_addr_t'(a * 4), 0);
            chk("reset_value", 0, q);
        end
    endtask : chk_reset
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #500us;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk_reset();
        apb(0, 12'h01C, 0);
        chk("unmapped_err", 1, {31'h0, err});
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1, `TMS_OFS_CTRL, {22'h0, rows[i].ctrl});
            apb(1, `TMS_OFS_CMPA, {16'h0, rows[i].cmpa});
            apb(1, `TMS_OFS_CAPT, {16'h0, rows[i].capt});
            apb(1, `TMS_OFS_FLAGS, 32'hF);
            apb(1, `TMS_OFS_COUNT, {16'h0, rows[i].cnt});
            apb(1, `TMS_OFS_CTRL, {19'h0, 3'h1, rows[i].ctrl});
            repeat (rows[i].cyc) @(posedge clk);
            apb(1, `TMS_OFS_CTRL, {22'h0, rows[i].ctrl});
            apb(0, `TMS_OFS_FLAGS, 0);
            chk("flags", {28'h0, rows[i].flg}, q & 32'hB);
            apb(0, `TMS_OFS_COUNT, 0);
            chk("count_side", {31'h0, rows[i].above}, {31'h0, q[15:0] > rows[i].bnd});
        end
        $display("test rows done");
        flag_ack <= 4'h1;
        @(posedge clk);
        flag_ack <= 4'h0;
        apb(0, `TMS_OFS_FLAGS, 0);
        chk("ack_clear", 0, {31'h0, q[0]});
        apb(1, `TMS_OFS_CTRL, 32'h114);
        apb(1, `TMS_OFS_CMPA, 32'h1);
        apb(1, `TMS_OFS_COUNT, 32'h0);
        apb(1, `TMS_OFS_CTRL, 32'h514);
        repeat (10) @(posedge clk);
        #1;
        oa0 = oa;
        chk("oe_a", 1, {31'h0, oea});
        repeat (2) @(posedge clk);
        #1;
        chk("toggle_a", {31'h0, ~oa0}, {31'h0, oa});
        apb(1, `TMS_OFS_CTRL, 32'h3E5);
        apb(1, `TMS_OFS_CMPA, 32'h1280);
        apb(0, `TMS_OFS_CMPA, 0);
        chk("cmpa_masked", 32'h80, q);
        apb(1, `TMS_OFS_CTRL, 32'h7E5);
        repeat (300) @(posedge clk);
        apb(1, `TMS_OFS_CTRL, 32'h3E5);
        apb(0, `TMS_OFS_COUNT, 0);
        c = q;
        apb(0, `TMS_OFS_STATUS, 0);
        chk("pwm_out_a", {31'h0, c[15:0] <= 16'h80}, {31'h0, q[16]});
        chk("pwm_out_b", {31'h0, c[15:0] != 16'h0}, {31'h0, ob});
        chk("oe_b", 1, {31'h0, oeb});
        $display("test waveform done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk_reset();
        $display("test mid reset done");
        report_and_stop();
    end
endmodule : tms_timer16_tb_top
